// *** common/osst_pkg.sv ***
// Purpose: Shared constants and types of the oscillator start and stabilization block.
// Assumes: A 125 MHz system clock and a 32-bit classic Wishbone register bus.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package osst_pkg;

  // ----------------------------------------------------------------------------
  // Bus geometry and register map
  // ----------------------------------------------------------------------------
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  REG_ENABLE      = 8'h00;
  localparam logic [7:0]  REG_CRYSTAL_CFG = 8'h04;
  localparam logic [7:0]  REG_HS_CFG      = 8'h08;
  localparam logic [7:0]  REG_FLAG        = 8'h0C;
  localparam logic [7:0]  REG_IRQ_EN      = 8'h10;
  localparam logic [7:0]  REG_KEY         = 8'h14;
  localparam logic [7:0]  REG_STATUS      = 8'h18;

  // ----------------------------------------------------------------------------
  // Source indices, shared by enable and gate bits; flag and interrupt enable bits use 0 to 2, bit 3 is stop
  // ----------------------------------------------------------------------------
  localparam int unsigned SRC_INTERNAL = 0;
  localparam int unsigned SRC_CRYSTAL  = 1;
  localparam int unsigned SRC_HS       = 2;
  localparam int unsigned SRC_EXTERNAL = 3;
  localparam int unsigned FLAG_STOP    = 3;

  // ----------------------------------------------------------------------------
  // Field positions of the crystal and high-speed configuration words
  // ----------------------------------------------------------------------------
  localparam int unsigned XCFG_WAIT_LSB  = 0;
  localparam int unsigned XCFG_NGAIN_LSB = 2;
  localparam int unsigned XCFG_GCAP_LSB  = 4;
  localparam int unsigned XCFG_BOOST_EN  = 7;
  localparam int unsigned XCFG_BGAIN_LSB = 8;
  localparam int unsigned XCFG_RESTART   = 10;
  localparam int unsigned XCFG_W         = 11;
  localparam int unsigned HCFG_TYPE_LSB  = 0;
  localparam int unsigned HCFG_WAIT_LSB  = 2;
  localparam int unsigned HCFG_FREQ_LSB  = 5;
  localparam int unsigned HCFG_W         = 7;

  // ----------------------------------------------------------------------------
  // Values after reset and protection key
  // ----------------------------------------------------------------------------
  localparam logic [3:0]        ENABLE_RST = 4'h1;
  localparam logic [XCFG_W-1:0] XCFG_RST   = 11'h000;
  localparam logic [HCFG_W-1:0] HCFG_RST   = 7'h00;
  localparam logic [15:0]       KEY_RST    = 16'h0000;
  localparam logic [15:0]       UNLOCK_KEY = 16'h0096;

  // ----------------------------------------------------------------------------
  // Stabilization, boost and stop detection counts
  // ----------------------------------------------------------------------------
  localparam logic [16:0] INTERNAL_WAIT   = 17'h00010;
  localparam logic [4:0]  XTAL_WAIT_SHIFT = 5'h0E;
  localparam logic [4:0]  HS_WAIT_SHIFT   = 5'h10;
  localparam logic [10:0] BOOST_CYCLES    = 11'h400;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned STOP_TIME_NS    = 200000;
  localparam int unsigned STOP_CYCLES     = STOP_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    OSST_SYS_INTERNAL,
    OSST_SYS_CRYSTAL,
    OSST_SYS_HS,
    OSST_SYS_EXTERNAL
  } osst_sys_src_t;

  typedef enum logic [1:0] {
    OSST_HS_CRYSTAL,
    OSST_HS_RC,
    OSST_HS_INTERNAL
  } osst_hs_type_t;

  typedef struct packed {
    logic       internal_run;
    logic       crystal_run;
    logic       high_speed_run;
    logic       external_en;
    logic [1:0] crystal_gain;
    logic [2:0] crystal_gate_cap;
    logic       crystal_restart;
    logic [1:0] high_speed_type;
    logic [1:0] high_speed_freq;
  } osst_ctrl_t;

endpackage : osst_pkg

// *** hdl/osst_core.sv ***
// Purpose: Starts the clock sources, times their stabilization and gates their clocks.
// Assumes: Oscillator outputs arrive as slow levels, each below a quarter of clk_i.
// Notes:   Wait lengths count rising edges of the oscillator itself, not clk_i cycles.
//
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module osst_core #(
  parameter int unsigned STOP_CYCLES = osst_pkg::STOP_CYCLES,
  parameter int unsigned STOP_W      = 16
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [osst_pkg::ADDR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic [2:0]                    osc_clk_i,
  output logic      [3:0]                    clk_gate_o,
  output osst_pkg::osst_ctrl_t               osc_ctrl_o,
  output osst_pkg::osst_sys_src_t            system_clk_sel_o,
  output logic                               irq_o
);

  // ----------------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------------
  if (STOP_CYCLES < 2 || STOP_CYCLES >= (1 << STOP_W)) begin : g_bad_stop
    $error("STOP_CYCLES does not fit the stop counter");
  end

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]                      sync1;
    logic [2:0]                      sync2;
    logic [2:0]                      prev;
    logic [2:0][16:0]                cnt;
    logic [2:0]                      waiting;
    logic [2:0]                      ready;
    logic [3:0]                      osc_en;
    logic [osst_pkg::XCFG_W-1:0]     xcfg;
    logic [osst_pkg::HCFG_W-1:0]     hcfg;
    logic [3:0]                      flag;
    logic [3:0]                      irq_en;
    logic [15:0]                     key;
    logic                            boost;
    logic [10:0]                     boost_cnt;
    logic [STOP_W-1:0]               stop_cnt;
    logic                            restart;
    logic                            ack;
    logic [31:0]                     rdata;
  } osst_state_t;

  osst_state_t q;
  osst_state_t d;

  logic [2:0]        edge_w;
  logic              req_w;
  logic              wr_w;
  logic [31:0]       wmask_w;
  logic [31:0]       wbits_w;
  logic              unlocked_w;
  logic [2:0][16:0]  target_w;
  logic [3:0]        set_w;
  logic              stop_w;
  logic [31:0]       rd_w;
  logic [3:0]        en_new;

  // ----------------------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------------------
  // Edge detect reads only the second synchroniser stage and its delayed copy.
  assign edge_w     = q.sync2 & ~q.prev;
  assign req_w      = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wr_w       = req_w & wb_we_i;
  assign wmask_w    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wbits_w    = wb_dat_i & wmask_w;
  assign unlocked_w = (q.key == osst_pkg::UNLOCK_KEY);

  // Wait targets in oscillator edges.
  assign target_w[osst_pkg::SRC_INTERNAL] = osst_pkg::INTERNAL_WAIT;
  assign target_w[osst_pkg::SRC_CRYSTAL]  = 17'h00001 << (osst_pkg::XTAL_WAIT_SHIFT -
      {2'h0, q.xcfg[osst_pkg::XCFG_WAIT_LSB +: 2], 1'b0});
  assign target_w[osst_pkg::SRC_HS]       = 17'h00001 << (osst_pkg::HS_WAIT_SHIFT -
      {1'b0, q.hcfg[osst_pkg::HCFG_WAIT_LSB +: 3], 1'b0});

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    rd_w = 32'h00000000;
    unique case (wb_adr_i)
      osst_pkg::REG_ENABLE:      rd_w[3:0]                  = q.osc_en;
      osst_pkg::REG_CRYSTAL_CFG: rd_w[osst_pkg::XCFG_W-1:0] = q.xcfg;
      osst_pkg::REG_HS_CFG:      rd_w[osst_pkg::HCFG_W-1:0] = q.hcfg;
      osst_pkg::REG_FLAG:        rd_w[3:0]                  = q.flag;
      osst_pkg::REG_IRQ_EN:      rd_w[3:0]                  = q.irq_en;
      osst_pkg::REG_KEY:         rd_w[15:0]                 = q.key;
      osst_pkg::REG_STATUS:      rd_w[4:0]                  = {q.boost, clk_gate_o};
      default:                   rd_w                       = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  // Bus access, stabilization counting, boost, stop detection and flags.
  always_comb begin
    logic [osst_pkg::XCFG_W-1:0] xnew;
    logic [osst_pkg::HCFG_W-1:0] hnew;
    xnew    = (q.xcfg & ~wmask_w[osst_pkg::XCFG_W-1:0]) | wbits_w[osst_pkg::XCFG_W-1:0];
    hnew    = (q.hcfg & ~wmask_w[osst_pkg::HCFG_W-1:0]) | wbits_w[osst_pkg::HCFG_W-1:0];
    d       = q;
    set_w   = 4'h0;
    stop_w  = 1'b0;
    en_new  = q.osc_en;
    d.sync1 = osc_clk_i;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    d.ack   = req_w;
    d.restart = 1'b0;
    if (req_w) begin
      d.rdata = rd_w;
    end
    // Register writes.
    if (wr_w) begin
      unique case (wb_adr_i)
        osst_pkg::REG_ENABLE: begin
          en_new = (q.osc_en & ~wmask_w[3:0]) | wbits_w[3:0];
        end
        osst_pkg::REG_CRYSTAL_CFG: begin
          if (unlocked_w) begin
            d.xcfg = xnew;
          end
        end
        osst_pkg::REG_HS_CFG: begin
          // The unused type code is refused and the old type kept.
          if (unlocked_w && hnew[osst_pkg::HCFG_TYPE_LSB +: 2] != 2'h3) begin
            d.hcfg = hnew;
          end
        end
        osst_pkg::REG_IRQ_EN: begin
          d.irq_en = (q.irq_en & ~wmask_w[3:0]) | wbits_w[3:0];
        end
        osst_pkg::REG_KEY: begin
          d.key = (q.key & ~wmask_w[15:0]) | wbits_w[15:0];
        end
        default: begin
        end
      endcase
    end
    // Stabilization counters advance on each oscillator edge while the source waits.
    for (int i = 0; i < 3; i++) begin
      if (q.waiting[i] && edge_w[i]) begin
        d.cnt[i] = q.cnt[i] + 17'h00001;
        if (q.cnt[i] + 17'h00001 == target_w[i]) begin
          d.waiting[i] = 1'b0;
          d.ready[i]   = 1'b1;
          set_w[i]     = 1'b1;
        end
      end
    end
    // Boost interval counted in crystal edges, then normal gain returns.
    if (q.boost && edge_w[osst_pkg::SRC_CRYSTAL]) begin
      d.boost_cnt = q.boost_cnt + 11'h001;
      if (q.boost_cnt + 11'h001 == osst_pkg::BOOST_CYCLES) begin
        d.boost = 1'b0;
      end
    end
    // Stop detector: too long without a crystal edge restarts the wait.
    if (q.ready[osst_pkg::SRC_CRYSTAL] && q.xcfg[osst_pkg::XCFG_RESTART]) begin
      if (edge_w[osst_pkg::SRC_CRYSTAL]) begin
        d.stop_cnt = '0;
      end else if (q.stop_cnt == STOP_W'(STOP_CYCLES - 1)) begin
        stop_w                          = 1'b1;
        d.stop_cnt                      = '0;
        d.restart                       = 1'b1;
        d.ready[osst_pkg::SRC_CRYSTAL]  = 1'b0;
        d.waiting[osst_pkg::SRC_CRYSTAL] = 1'b1;
        d.cnt[osst_pkg::SRC_CRYSTAL]    = 17'h00000;
        set_w[osst_pkg::FLAG_STOP]      = 1'b1;
      end else begin
        d.stop_cnt = q.stop_cnt + STOP_W'(1);
      end
    end else begin
      d.stop_cnt = '0;
    end
    // Enable edges start or stop each waited source.
    for (int i = 0; i < 3; i++) begin
      if (!en_new[i]) begin
        d.waiting[i] = 1'b0;
        d.ready[i]   = 1'b0;
        d.cnt[i]     = 17'h00000;
      end else if (!q.osc_en[i]) begin
        d.waiting[i] = 1'b1;
        d.ready[i]   = 1'b0;
        d.cnt[i]     = 17'h00000;
      end
    end
    if (en_new[osst_pkg::SRC_CRYSTAL] && !q.osc_en[osst_pkg::SRC_CRYSTAL]) begin
      d.boost     = q.xcfg[osst_pkg::XCFG_BOOST_EN];
      d.boost_cnt = 11'h000;
    end else if (!en_new[osst_pkg::SRC_CRYSTAL]) begin
      d.boost = 1'b0;
    end
    d.osc_en = en_new;
    // Flags: write one clears, a set in the same cycle wins.
    if (wr_w && wb_adr_i == osst_pkg::REG_FLAG) begin
      d.flag = q.flag & ~wbits_w[3:0];
    end
    d.flag = d.flag | set_w;
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  // Synchronous reset; the internal oscillator restarts its wait after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q         <= '0;
      q.osc_en  <= osst_pkg::ENABLE_RST;
      q.waiting <= 3'h1;
      q.xcfg    <= osst_pkg::XCFG_RST;
      q.hcfg    <= osst_pkg::HCFG_RST;
      q.key     <= osst_pkg::KEY_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // Clock gates, oscillator controls and interrupt request.
  assign wb_dat_o         = q.rdata;
  assign wb_ack_o         = q.ack;
  assign system_clk_sel_o = osst_pkg::OSST_SYS_INTERNAL;
  assign clk_gate_o       = {q.osc_en[osst_pkg::SRC_EXTERNAL], q.ready};
  assign irq_o            = |(q.flag & q.irq_en);
  assign osc_ctrl_o.internal_run     = q.osc_en[osst_pkg::SRC_INTERNAL];
  assign osc_ctrl_o.crystal_run      = q.osc_en[osst_pkg::SRC_CRYSTAL];
  assign osc_ctrl_o.high_speed_run   = q.osc_en[osst_pkg::SRC_HS];
  assign osc_ctrl_o.external_en      = q.osc_en[osst_pkg::SRC_EXTERNAL];
  assign osc_ctrl_o.crystal_gain     = q.boost ? q.xcfg[osst_pkg::XCFG_BGAIN_LSB +: 2]
                                               : q.xcfg[osst_pkg::XCFG_NGAIN_LSB +: 2];
  assign osc_ctrl_o.crystal_gate_cap = q.xcfg[osst_pkg::XCFG_GCAP_LSB +: 3];
  assign osc_ctrl_o.crystal_restart  = q.restart;
  assign osc_ctrl_o.high_speed_type  = q.hcfg[osst_pkg::HCFG_TYPE_LSB +: 2];
  assign osc_ctrl_o.high_speed_freq  =
      (q.hcfg[osst_pkg::HCFG_TYPE_LSB +: 2] == osst_pkg::OSST_HS_INTERNAL)
      ? q.hcfg[osst_pkg::HCFG_FREQ_LSB +: 2] : 2'h0;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic wr_en_w;
  assign wr_en_w = wr_w && wb_adr_i == osst_pkg::REG_ENABLE && wb_sel_i[0];

  AST_BOOT_INTERNAL: assert property ($fell(rst_i) |-> osc_ctrl_o.internal_run
      && q.waiting[0] && system_clk_sel_o == osst_pkg::OSST_SYS_INTERNAL)
    else $error("internal oscillator not running after reset");
  AST_GATE_AFTER_WAIT: assert property ($rose(clk_gate_o[2]) |-> $past(q.waiting[2]))
    else $error("high-speed clock opened without a wait");
  // The expected length is worked out here from the field, apart from target_w.
  AST_XTAL_TARGET: assert property ($rose(q.ready[1]) |->
      $past(q.cnt[1]) + 17'h00001 ==
      (17'h04000 >> {$past(q.xcfg[osst_pkg::XCFG_WAIT_LSB +: 2]), 1'b0}))
    else $error("crystal wait length wrong");
  AST_INTERNAL_WAIT: assert property ($rose(q.ready[0]) |-> $past(q.cnt[0]) == 17'h0000F)
    else $error("internal oscillator wait not sixteen edges");
  AST_FLAG_WITH_GATE: assert property ($rose(clk_gate_o[1]) |-> q.flag[1])
    else $error("crystal gate opened without its flag");
  AST_RESTART_WAIT: assert property (wr_en_w && wb_dat_i[1] && !q.osc_en[1] |=>
      q.waiting[1] && !clk_gate_o[1] && q.cnt[1] == 17'h00000)
    else $error("crystal start did not rerun the wait");
  AST_BOOST_GAIN: assert property (q.boost |->
      osc_ctrl_o.crystal_gain == q.xcfg[osst_pkg::XCFG_BGAIN_LSB +: 2] && q.osc_en[1])
    else $error("boost gain not applied");
  AST_FLAG_CLEAR: assert property (wr_w && wb_adr_i == osst_pkg::REG_FLAG && wb_sel_i[0]
      && wb_dat_i[0] && !set_w[0] |=> !q.flag[0])
    else $error("ready flag not cleared by writing one");
  AST_LOCKED: assert property (wr_w && wb_adr_i == osst_pkg::REG_CRYSTAL_CFG
      && !unlocked_w |=> $stable(q.xcfg))
    else $error("locked crystal configuration changed");
  AST_RELOCK: assert property (wr_w && wb_adr_i == osst_pkg::REG_KEY && wb_sel_i[1:0] == 2'h3
      && wb_dat_i[15:0] != osst_pkg::UNLOCK_KEY |=> !unlocked_w)
    else $error("key write did not relock");
  AST_EXT_NO_WAIT: assert property (wr_en_w && wb_dat_i[3] |=> clk_gate_o[3])
    else $error("external clock not passed at once");
  AST_HS_TYPE: assert property (osc_ctrl_o.high_speed_type != 2'h3)
    else $error("illegal high-speed type");
  AST_STOP_RESTART: assert property (stop_w && !wr_en_w |=> q.waiting[1] && q.flag[3]
      && osc_ctrl_o.crystal_restart)
    else $error("stop detector did not restart crystal");
  AST_IRQ: assert property ($rose(q.flag[0]) && q.irq_en[0] |-> irq_o)
    else $error("interrupt not raised for ready flag");

  COV_INTERNAL_READY: cover property ($rose(q.ready[0]));
  COV_CRYSTAL_BOOST:  cover property ($fell(q.boost) && q.osc_en[1]);
  COV_HS_READY:       cover property ($rose(clk_gate_o[2]));
  COV_STOP:           cover property (stop_w);

endmodule : osst_core

// *** test/osst_core_bench.sv ***
// Purpose: Self-checking bench of the oscillator start and stabilization core.
// Assumes: The bench models each oscillator as a square wave of eight clk_i cycles.
// Notes:   Stop detection is shortened to 64 cycles so a lost crystal shows up quickly.
`timescale 1ns/1ps

module osst_core_bench;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    wb_cyc = 1'b0;
  logic                    wb_we = 1'b0;
  logic [7:0]              wb_adr = 8'h00;
  logic [31:0]             wb_dat = 32'h0;
  logic [3:0]              wb_sel = 4'hF;
  logic [31:0]             wb_dat_o;
  logic [31:0]             rdv;
  logic [31:0]             xc;
  logic                    wb_ack_o;
  logic                    irq_o;
  logic [3:0]              clk_gate_o;
  logic [3:0]              en = 4'h1;
  logic [2:0]              osc = 3'h0;
  logic [2:0]              osc_on = 3'h0;
  logic [2:0]              en_q = 3'h0;
  logic [2:0]              div = 3'h0;
  logic [15:0]             lfsr = 16'h6C20;
  osst_pkg::osst_ctrl_t    ctrl;
  osst_pkg::osst_sys_src_t sys_sel;
  int                      cnt [3];
  int                      fail_count = 0;
  int                      compares = 0;

  // The clock toggles every half period of 4 ns.
  always #4 clk_i = ~clk_i;

  osst_core #(.STOP_CYCLES(64)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .osc_clk_i(osc), .clk_gate_o(clk_gate_o), .osc_ctrl_o(ctrl),
    .system_clk_sel_o(sys_sel), .irq_o(irq_o));

  // Oscillators start and stop only while low, so no pulse is ever cut short.
  always @(posedge clk_i) begin
    div <= div + 3'h1;
    if (div == 3'h7) en_q <= osc_on;
    osc <= en_q & {3{div >= 3'h3 && div <= 3'h6}};
    for (int i = 0; i < 3; i++) begin
      if (!en_q[i]) cnt[i] <= 0;
      else if (div == 3'h3) cnt[i] <= cnt[i] + 1;
    end
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt

  // Expected wait in oscillator edges for a given wait selection.
  function automatic int tgt(input int base, input int sel);
    return 1 << (base - 2 * sel);
  endfunction : tgt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One classic bus cycle; the request holds until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rdv = wb_dat_o;
    chk(32'(n), 32'h2, "bus latency");
    wb_cyc <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  // Waits until an oscillator has made n rising edges, then lets the sync settle.
  task automatic upto(input int i, input int n);
    int k;
    k = 0;
    while (cnt[i] < n && k < 20000) begin
      @(posedge clk_i);
      k++;
    end
    chk(32'(k < 20000), 32'h1, "edge wait");
    repeat (6) @(posedge clk_i);
  endtask : upto

  // Enables a source and checks that its gate opens exactly at the n-th edge.
  task automatic start(input int i, input int n);
    osc_on[i] <= 1'b0;
    repeat (10) @(posedge clk_i);
    en[i] = 1'b1;
    bus(1'b1, osst_pkg::REG_ENABLE, {28'h0, en});
    osc_on[i] <= 1'b1;
    upto(i, n - 1);
    chk(32'(clk_gate_o[i]), 32'h0, "gate early");
    upto(i, n);
    chk(32'(clk_gate_o[i]), 32'h1, "gate late");
    bus(1'b0, osst_pkg::REG_FLAG, 32'h0);
    chk(32'(rdv[i]), 32'h1, "ready flag");
  endtask : start

  task automatic finish_test();
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  // A hung wait is cut short here, well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    finish_test();
  end

  // Main scenario list.
  initial begin
    logic [1:0] f;
    logic [2:0] s;
    repeat (2) @(posedge clk_i);
    chk(32'(ctrl), 32'h2000, "ctrl at reset");
    chk(32'(sys_sel), 32'h0, "system clock source");
    chk({27'h0, irq_o, clk_gate_o}, 32'h0, "gates at reset");
    rst_i <= 1'b0;
    osc_on[0] <= 1'b1;
    upto(0, 15);
    chk(32'(clk_gate_o[0]), 32'h0, "internal early");
    upto(0, 16);
    chk(32'(clk_gate_o[0]), 32'h1, "internal late");
    bus(1'b1, osst_pkg::REG_IRQ_EN, 32'h1);
    chk(32'(irq_o), 32'h1, "irq raised");
    bus(1'b1, osst_pkg::REG_FLAG, 32'hE);
    bus(1'b0, osst_pkg::REG_FLAG, 32'h0);
    chk(rdv & 32'h1, 32'h1, "flag kept on zero");
    bus(1'b1, osst_pkg::REG_IRQ_EN, 32'h0);
    chk(32'(irq_o), 32'h0, "irq masked");
    // A one written on a masked byte lane must not clear the flag.
    wb_sel <= 4'hE;
    bus(1'b1, osst_pkg::REG_FLAG, 32'h1);
    wb_sel <= 4'hF;
    bus(1'b0, osst_pkg::REG_FLAG, 32'h0);
    chk(rdv & 32'h1, 32'h1, "flag kept on masked lane");
    bus(1'b1, osst_pkg::REG_FLAG, 32'h1);
    bus(1'b0, osst_pkg::REG_FLAG, 32'h0);
    chk(rdv & 32'h1, 32'h0, "flag cleared");
    bus(1'b0, 8'h1C, 32'h0);
    chk(rdv, 32'h0, "unmapped read");
    // Restart of the internal oscillator in the software order: clear, enable, start.
    en[0] = 1'b0;
    bus(1'b1, osst_pkg::REG_ENABLE, {28'h0, en});
    bus(1'b1, osst_pkg::REG_FLAG, 32'h1);
    bus(1'b1, osst_pkg::REG_IRQ_EN, 32'h1);
    start(0, 16);
    chk(32'(irq_o), 32'h1, "irq on restart");
    bus(1'b1, osst_pkg::REG_IRQ_EN, 32'h0);
    en[3] = 1'b1;
    bus(1'b1, osst_pkg::REG_ENABLE, {28'h0, en});
    chk(32'(clk_gate_o[3]), 32'h1, "external at once");
    lfsr = nxt(lfsr);
    xc = {22'h0, ~lfsr[1:0], 1'b1, lfsr[4:2], lfsr[1:0], 2'h3};
    bus(1'b1, osst_pkg::REG_CRYSTAL_CFG, xc);
    bus(1'b0, osst_pkg::REG_CRYSTAL_CFG, 32'h0);
    chk(rdv, 32'h0, "locked write");
    bus(1'b1, osst_pkg::REG_KEY, {16'h0, osst_pkg::UNLOCK_KEY});
    bus(1'b1, osst_pkg::REG_CRYSTAL_CFG, xc);
    bus(1'b0, osst_pkg::REG_CRYSTAL_CFG, 32'h0);
    chk(rdv, xc, "unlocked write");
    for (int t = 0; t < 3; t++) begin
      lfsr = nxt(lfsr);
      f = lfsr[1:0] | 2'h1;
      // The resonator type gets at least 1024 edges, the others at least four.
      s = (t == 0) ? 3'h3 : 3'(7 - t);
      bus(1'b1, osst_pkg::REG_HS_CFG, {25'h0, f, s, 2'(t)});
      chk(32'(ctrl.high_speed_type), t, "hs type");
      chk(32'(ctrl.high_speed_freq), (t == 2) ? 32'(f) : 32'h0, "hs freq");
      start(2, tgt(16, int'(s)));
      en[2] = 1'b0;
      bus(1'b1, osst_pkg::REG_ENABLE, {28'h0, en});
    end
    lfsr = nxt(lfsr);
    bus(1'b1, osst_pkg::REG_KEY, {16'h0, lfsr | 16'h0100});
    bus(1'b1, osst_pkg::REG_CRYSTAL_CFG, 32'h0);
    bus(1'b0, osst_pkg::REG_CRYSTAL_CFG, 32'h0);
    chk(rdv, xc, "relocked write");
    start(1, tgt(14, 3));
    chk(32'(ctrl.crystal_gain), 32'(xc[9:8]), "boost gain");
    bus(1'b0, osst_pkg::REG_STATUS, 32'h0);
    chk(rdv & 32'h12, 32'h12, "status boost and gate");
    upto(1, 1023);
    chk(32'(ctrl.crystal_gain), 32'(xc[9:8]), "boost held");
    upto(1, 1024);
    chk(32'(ctrl.crystal_gain), 32'(xc[3:2]), "normal gain");
    chk(32'(ctrl.crystal_gate_cap), 32'(xc[6:4]), "gate cap");
    en[1] = 1'b0;
    bus(1'b1, osst_pkg::REG_ENABLE, {28'h0, en});
    chk(32'(clk_gate_o[1]), 32'h0, "crystal stopped");
    start(1, tgt(14, 3));
    bus(1'b1, osst_pkg::REG_KEY, {16'h0, osst_pkg::UNLOCK_KEY});
    bus(1'b1, osst_pkg::REG_CRYSTAL_CFG, xc | 32'h400);
    osc_on[1] <= 1'b0;
    repeat (100) @(posedge clk_i);
    bus(1'b0, osst_pkg::REG_FLAG, 32'h0);
    chk(rdv & 32'h8, 32'h8, "stop flag");
    chk(32'(clk_gate_o[1]), 32'h0, "stopped gate");
    finish_test();
  end
endmodule : osst_core_bench
